// *** rtl/mbs_pkg.sv ***
// Purpose: Shared constants, types and helpers for the serial parameter slave.
// Assumes: 25 MHz core clock, 9600 baud, 11-bit characters.
// Notes: The inter-frame gap is 3.5 characters, rounded up to whole cycles.
package mbs_pkg;
	localparam int CLK_HZ = 25_000_000;
	localparam int BAUD_DEF = 9600;
	localparam int BIT_CYC = CLK_HZ / BAUD_DEF;
	localparam int CHAR_BITS = 11;
	localparam int GAP_HALF_CHARS = 7;
	localparam int GAP_CYC = (BIT_CYC * CHAR_BITS * GAP_HALF_CHARS + 1) / 2;
	localparam int IDX_BITS_DEF = 4;
	localparam int FRAME_MAX = 32;
	localparam int HDR_BYTES = 7;
	localparam logic [5:0] LEN_SHORT = 6'h08;
	localparam logic [5:0] LEN_WRN_BASE = 6'h09;
	localparam logic [5:0] RSP_ECHO_LEN = 6'h08;
	localparam logic [5:0] RSP_EXC_LEN = 6'h05;
	localparam logic [5:0] RSP_RD_BASE = 6'h05;
	localparam logic [5:0] WR_DATA_POS = 6'h07;
	localparam logic [7:0] ADDR_BCAST = 8'h00;
	localparam logic [7:0] CMD_READ = 8'h03;
	localparam logic [7:0] CMD_WR1 = 8'h06;
	localparam logic [7:0] CMD_WRN = 8'h10;
	localparam logic [7:0] CMD_WR1_NV = 8'h41;
	localparam logic [7:0] CMD_WRN_NV = 8'h43;
	localparam logic [7:0] EXC_FLAG = 8'h80;
	localparam logic [7:0] EX_NONE = 8'h00;
	localparam logic [7:0] EX_CMD = 8'h01;
	localparam logic [7:0] EX_ADDR = 8'h02;
	localparam logic [7:0] EX_DATA = 8'h03;
	localparam logic [7:0] EX_FRAME = 8'h18;
	localparam logic [7:0] EX_RO = 8'h20;
	localparam logic [15:0] CNT_MIN = 16'h0001;
	localparam logic [15:0] CNT_MAX = 16'h000A;
	localparam logic [15:0] CRC_INIT = 16'hFFFF;
	localparam logic [15:0] CRC_POLY = 16'hA001;
	localparam logic [15:0] REG_CTRL_WORD_ONE = 16'h6400;
	localparam logic [15:0] REG_PERSIST_SEL = 16'h0F04;
	localparam logic [15:0] CTRL_WORD_ONE_RST = 16'h0000;
	localparam logic PERSIST_SEL_RST = 1'b0;
	localparam logic [7:0] GRP_LAST_PLAIN = 8'h10;
	localparam logic [7:0] GRP_18 = 8'h12;
	localparam logic [7:0] GRP_19 = 8'h13;
	localparam logic [7:0] GRP_23 = 8'h17;
	localparam logic [7:0] GRP_CTRL = 8'h64;
	localparam logic [7:0] GRP_STAT = 8'h65;
	localparam logic [4:0] SLOT_G18 = 5'h11;
	localparam logic [4:0] SLOT_G19 = 5'h12;
	localparam logic [4:0] SLOT_G23 = 5'h13;
	localparam logic [4:0] SLOT_CTRL = 5'h14;
	localparam logic [4:0] SLOT_STAT = 5'h15;
	localparam logic [4:0] SLOT_NONE = 5'h1F;

	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_CHECK = 6'h02,
		ST_WHI = 6'h04,
		ST_WLO = 6'h08,
		ST_WPUT = 6'h10,
		ST_TX = 6'h20
	} mbs_state_t;

	typedef enum logic [1:0] {
		RSP_READ = 2'h0,
		RSP_ECHO = 2'h1,
		RSP_EXC = 2'h2
	} mbs_rsp_t;

	function automatic logic [15:0] mbs_crc_byte(input logic [15:0] crc, input logic [7:0] data);
		logic [15:0] c;
		c = crc ^ {8'h00, data};
		for (int i = 0; i < 8; i++)
			c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
		return c;
	endfunction : mbs_crc_byte

	function automatic logic [4:0] mbs_grp_slot(input logic [7:0] hi);
		logic [4:0] s;
		s = SLOT_NONE;
		if (hi <= GRP_LAST_PLAIN)
			s = hi[4:0];
		else if (hi == GRP_18)
			s = SLOT_G18;
		else if (hi == GRP_19)
			s = SLOT_G19;
		else if (hi == GRP_23)
			s = SLOT_G23;
		else if (hi == GRP_CTRL)
			s = SLOT_CTRL;
		else if (hi == GRP_STAT)
			s = SLOT_STAT;
		return s;
	endfunction : mbs_grp_slot
endpackage : mbs_pkg

// *** rtl/mbs_ram.sv ***
// Purpose: Simple dual-port memory with registered read data.
// Assumes: One write port and one read port on the same clock.
// Notes: Contents are not reset.
`timescale 1ns/1ps
module mbs_ram #(
	parameter int WIDTH = 16,
	parameter int AW = 9
) (
	// Clock
	input wire logic core_clk,
	// Write port
	input wire logic wrEn,
	input wire logic [AW-1:0] wrAddr,
	input wire logic [WIDTH-1:0] wrData,
	// Read port
	input wire logic [AW-1:0] rdAddr,
	output logic [WIDTH-1:0] rdData
);
	logic [WIDTH-1:0] mem [2**AW];

	always_ff @(posedge core_clk)
	begin
		if (wrEn)
			mem[wrAddr] <= wrData;
	end

	always_ff @(posedge core_clk)
	begin
		rdData <= mem[rdAddr];
	end
endmodule : mbs_ram

// *** rtl/mbs_slave.sv ***
// Purpose: RTU slave that reads and writes drive parameters over a half-duplex line.
// Assumes: Fixed 1-8-N-2 framing; station address is a static input.
// Notes: Received bytes are ignored while a reply is being prepared or sent.
`timescale 1ns/1ps
module mbs_slave #(
	parameter int GAP_CYC = mbs_pkg::GAP_CYC,
	parameter int BIT_CYC = mbs_pkg::BIT_CYC,
	parameter int IDX_BITS = mbs_pkg::IDX_BITS_DEF
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// Configuration
	input wire logic [7:0] stationAddr,
	// Serial line
	input wire logic rxd,
	output logic txd,
	output logic txEn,
	// Nonvolatile save request
	output logic nvWrStb,
	output logic [15:0] nvWrAddr,
	output logic [15:0] nvWrData,
	// Parameter shadows
	output logic [15:0] controlWordOne,
	output logic persistSel
);
	localparam int AW = 5 + IDX_BITS;

	mbs_pkg::mbs_state_t state;
	mbs_pkg::mbs_rsp_t rspKind;
	logic [2:0] rxSync;
	logic rxLevel, rxBusy, rxStb, ovf, frameOk, txBusy, isRd, isW1, isWn, nvCmd;
	logic [15:0] rxTmr, txTmr, rxCrc, txCrc, nReq, regAddr, pRd, pWrData;
	logic [3:0] rxBit, txBitCnt, nWords, wK;
	logic [7:0] rxSh, excCode, txByte, hiByte, bufRd, excHeld;
	logic [7:0] hdr [mbs_pkg::HDR_BYTES];
	logic [19:0] gapCnt;
	logic [5:0] rxCnt, txIdx, txLen, expLen, bufRdAddr;
	logic [10:0] txSh;
	logic [AW-1:0] pRdAddr, pWrAddr;
	logic [4:0] slot;
	logic frameEnd, txLoad, txFin;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);

	function automatic logic [AW-1:0] wordAddr(input logic [4:0] s, input logic [7:0] idx,
		input logic [3:0] k);
		logic [7:0] i;
		i = idx + {4'h0, k};
		return {s, i[IDX_BITS-1:0]};
	endfunction : wordAddr

	////////////////////////////////////////////////////////////////////////////////
	// Receive side. The line is filtered so that a one-cycle glitch cannot start a byte.
	always_ff @(posedge core_clk)
	begin
		if (!rst_b)
		begin
			rxSync <= 3'h7;
			rxLevel <= 1'b1;
		end
		else
		begin
			rxSync <= {rxSync[1:0], rxd};
			if (rxSync[1] == rxSync[2])
				rxLevel <= rxSync[2];
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_b)
		begin
			rxBusy <= 1'b0;
			rxTmr <= 16'h0000;
			rxBit <= 4'h0;
			rxSh <= 8'h00;
			rxStb <= 1'b0;
		end
		else
		begin
			rxStb <= 1'b0;
			if (!rxBusy)
			begin
				if (!rxLevel)
				begin
					rxBusy <= 1'b1;
					rxTmr <= 16'(BIT_CYC / 2);
					rxBit <= 4'h0;
				end
			end
			else if (rxTmr != 16'h0000)
				rxTmr <= rxTmr - 16'h0001;
			else
			begin
				rxTmr <= 16'(BIT_CYC - 1);
				rxBit <= rxBit + 4'h1;
				if (rxBit == 4'h0 && rxLevel)
					rxBusy <= 1'b0;
				else if (rxBit == 4'h9)
				begin
					rxBusy <= 1'b0;
					rxStb <= rxLevel;
				end
				else if (rxBit != 4'h0)
					rxSh <= {rxLevel, rxSh[7:1]};
			end
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_b)
			gapCnt <= 20'(GAP_CYC);
		else if (rxBusy || !rxLevel)
			gapCnt <= 20'h00000;
		else if (gapCnt != 20'(GAP_CYC))
			gapCnt <= gapCnt + 20'h00001;
	end
	assign frameEnd = (gapCnt == 20'(GAP_CYC - 1));

	always_ff @(posedge core_clk)
	begin
		if (!rst_b)
		begin
			rxCnt <= 6'h00;
			ovf <= 1'b0;
			rxCrc <= mbs_pkg::CRC_INIT;
			for (int i = 0; i < mbs_pkg::HDR_BYTES; i++)
				hdr[i] <= 8'h00;
		end
		else if (state == mbs_pkg::ST_CHECK)
		begin
			rxCnt <= 6'h00;
			ovf <= 1'b0;
			rxCrc <= mbs_pkg::CRC_INIT;
		end
		else if (state == mbs_pkg::ST_IDLE && rxStb)
		begin
			if (rxCnt == 6'(mbs_pkg::FRAME_MAX))
				ovf <= 1'b1;
			else
				rxCnt <= rxCnt + 6'h01;
			rxCrc <= mbs_pkg::mbs_crc_byte(rxCrc, rxSh);
			if (rxCnt < 6'(mbs_pkg::HDR_BYTES))
				hdr[rxCnt[2:0]] <= rxSh;
		end
	end

	mbs_ram #(.WIDTH(8), .AW(5)) uFrameBuf (
		.core_clk(core_clk),
		.wrEn(state == mbs_pkg::ST_IDLE && rxStb && rxCnt != 6'(mbs_pkg::FRAME_MAX)),
		.wrAddr(rxCnt[4:0]),
		.wrData(rxSh),
		.rdAddr(bufRdAddr[4:0]),
		.rdData(bufRd)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Request decode. Header bytes stay frozen until the machine returns to idle.
	assign regAddr = {hdr[2], hdr[3]};
	assign isRd = (hdr[1] == mbs_pkg::CMD_READ);
	assign isW1 = (hdr[1] == mbs_pkg::CMD_WR1) || (hdr[1] == mbs_pkg::CMD_WR1_NV);
	assign isWn = (hdr[1] == mbs_pkg::CMD_WRN) || (hdr[1] == mbs_pkg::CMD_WRN_NV);
	assign nvCmd = (hdr[1] == mbs_pkg::CMD_WR1_NV) || (hdr[1] == mbs_pkg::CMD_WRN_NV);
	assign slot = mbs_pkg::mbs_grp_slot(hdr[2]);
	assign nReq = isW1 ? mbs_pkg::CNT_MIN : {hdr[4], hdr[5]};
	assign expLen = isWn ? mbs_pkg::LEN_WRN_BASE + {nReq[4:0], 1'b0} : mbs_pkg::LEN_SHORT;
	assign frameOk = !ovf && rxCnt >= 6'h04 && rxCrc == 16'h0000 &&
		hdr[0] == stationAddr && hdr[0] != mbs_pkg::ADDR_BCAST;

	always_comb
	begin
		excCode = mbs_pkg::EX_NONE;
		if (!isRd && !isW1 && !isWn)
			excCode = mbs_pkg::EX_CMD;
		else if (nReq < mbs_pkg::CNT_MIN || nReq > mbs_pkg::CNT_MAX)
			excCode = mbs_pkg::EX_DATA;
		else if (rxCnt != expLen || (isWn && hdr[6] != {nReq[6:0], 1'b0}))
			excCode = mbs_pkg::EX_FRAME;
		else if (slot == mbs_pkg::SLOT_NONE ||
			(9'(hdr[3]) + nReq[8:0]) > 9'(2 ** IDX_BITS))
			excCode = mbs_pkg::EX_ADDR;
		else if (!isRd && hdr[2] == mbs_pkg::GRP_STAT)
			excCode = mbs_pkg::EX_RO;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Control sequence.
	always_ff @(posedge core_clk)
	begin
		if (!rst_b)
		begin
			state <= mbs_pkg::ST_IDLE;
			rspKind <= mbs_pkg::RSP_EXC;
			txLen <= mbs_pkg::RSP_EXC_LEN;
			excHeld <= mbs_pkg::EX_NONE;
			nWords <= 4'h0;
			wK <= 4'h0;
		end
		else
		begin
			unique case (state)
				mbs_pkg::ST_IDLE:
					if (frameEnd && rxCnt != 6'h00)
						state <= mbs_pkg::ST_CHECK;
				mbs_pkg::ST_CHECK:
				begin
					nWords <= nReq[3:0];
					wK <= 4'h0;
					// cause held for reply
					// The frame counters restart after checking, so the live cause would drift.
					excHeld <= excCode;
					if (!frameOk)
						state <= mbs_pkg::ST_IDLE;
					else if (excCode != mbs_pkg::EX_NONE)
					begin
						rspKind <= mbs_pkg::RSP_EXC;
						txLen <= mbs_pkg::RSP_EXC_LEN;
						state <= mbs_pkg::ST_TX;
					end
					else if (isRd)
					begin
						rspKind <= mbs_pkg::RSP_READ;
						txLen <= mbs_pkg::RSP_RD_BASE + {1'b0, nReq[3:0], 1'b0};
						state <= mbs_pkg::ST_TX;
					end
					else
					begin
						rspKind <= mbs_pkg::RSP_ECHO;
						txLen <= mbs_pkg::RSP_ECHO_LEN;
						state <= isW1 ? mbs_pkg::ST_WPUT : mbs_pkg::ST_WHI;
					end
				end
				mbs_pkg::ST_WHI:
					state <= mbs_pkg::ST_WLO;
				mbs_pkg::ST_WLO:
					state <= mbs_pkg::ST_WPUT;
				mbs_pkg::ST_WPUT:
				begin
					wK <= wK + 4'h1;
					state <= (wK + 4'h1 == nWords) ? mbs_pkg::ST_TX : mbs_pkg::ST_WHI;
				end
				mbs_pkg::ST_TX:
					if (txFin)
						state <= mbs_pkg::ST_IDLE;
				default:
					state <= mbs_pkg::ST_IDLE;
			endcase
		end
	end

	// data words arrive high byte first
	always_ff @(posedge core_clk)
	begin
		if (!rst_b)
		begin
			bufRdAddr <= 6'h00;
			hiByte <= 8'h00;
		end
		else
		begin
			if (state == mbs_pkg::ST_CHECK)
				bufRdAddr <= mbs_pkg::WR_DATA_POS;
			else if (state == mbs_pkg::ST_WHI || state == mbs_pkg::ST_WPUT)
				bufRdAddr <= bufRdAddr + 6'h01;
			if (state == mbs_pkg::ST_WLO)
				hiByte <= bufRd;
		end
	end

	assign pWrAddr = wordAddr(slot, hdr[3], wK);
	assign pWrData = isW1 ? {hdr[4], hdr[5]} : {hiByte, bufRd};
	assign pRdAddr = wordAddr(slot, hdr[3], 4'((txIdx - 6'h03) >> 1));

	// Parameters only change after the whole frame has passed its CRC check.
	mbs_ram #(.WIDTH(16), .AW(AW)) uParam (
		.core_clk(core_clk),
		.wrEn(state == mbs_pkg::ST_WPUT),
		.wrAddr(pWrAddr),
		.wrData(pWrData),
		.rdAddr(pRdAddr),
		.rdData(pRd)
	);

	always_ff @(posedge core_clk)
	begin
		if (!rst_b)
		begin
			nvWrStb <= 1'b0;
			nvWrAddr <= 16'h0000;
			nvWrData <= 16'h0000;
			controlWordOne <= mbs_pkg::CTRL_WORD_ONE_RST;
			persistSel <= mbs_pkg::PERSIST_SEL_RST;
		end
		else
		begin
			nvWrStb <= 1'b0;
			if (state == mbs_pkg::ST_WPUT)
			begin
				if (nvCmd || persistSel)
				begin
					nvWrStb <= 1'b1;
					nvWrAddr <= regAddr + {12'h000, wK};
					nvWrData <= pWrData;
				end
				if (regAddr + {12'h000, wK} == mbs_pkg::REG_CTRL_WORD_ONE)
					controlWordOne <= pWrData;
				if (regAddr + {12'h000, wK} == mbs_pkg::REG_PERSIST_SEL)
					persistSel <= pWrData[0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Reply side. The driver enable stays high across the whole reply, not per byte.
	assign txLoad = state == mbs_pkg::ST_TX && !txBusy && txIdx != txLen;
	assign txFin = state == mbs_pkg::ST_TX && !txBusy && txIdx == txLen;

	always_comb
	begin
		txByte = hdr[0];
		if (txIdx == txLen - 6'h02)
			txByte = txCrc[7:0];
		else if (txIdx == txLen - 6'h01)
			txByte = txCrc[15:8];
		else
			unique case (rspKind)
				mbs_pkg::RSP_EXC:
					if (txIdx == 6'h01)
						txByte = hdr[1] | mbs_pkg::EXC_FLAG;
					else if (txIdx == 6'h02)
						txByte = excHeld;
				mbs_pkg::RSP_ECHO:
					txByte = hdr[txIdx[2:0]];
				mbs_pkg::RSP_READ:
					if (txIdx == 6'h01)
						txByte = hdr[1];
					else if (txIdx == 6'h02)
						txByte = {3'h0, nWords, 1'b0};
					else if (txIdx != 6'h00)
						txByte = txIdx[0] ? pRd[15:8] : pRd[7:0];
				default:
					txByte = hdr[0];
			endcase
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_b)
		begin
			txd <= 1'b1;
			txEn <= 1'b0;
			txBusy <= 1'b0;
			txSh <= 11'h7FF;
			txBitCnt <= 4'h0;
			txTmr <= 16'h0000;
			txIdx <= 6'h00;
			txCrc <= mbs_pkg::CRC_INIT;
		end
		else if (state == mbs_pkg::ST_CHECK)
		begin
			txIdx <= 6'h00;
			txCrc <= mbs_pkg::CRC_INIT;
		end
		else if (txBusy)
		begin
			if (txTmr != 16'h0000)
				txTmr <= txTmr - 16'h0001;
			else if (txBitCnt == 4'(mbs_pkg::CHAR_BITS - 1))
				txBusy <= 1'b0;
			else
			begin
				txTmr <= 16'(BIT_CYC - 1);
				txBitCnt <= txBitCnt + 4'h1;
				txd <= txSh[1];
				txSh <= {1'b1, txSh[10:1]};
			end
		end
		else if (txFin)
		begin
			txEn <= 1'b0;
			txd <= 1'b1;
		end
		else if (txLoad)
		begin
			txEn <= 1'b1;
			txBusy <= 1'b1;
			txd <= 1'b0;
			txSh <= {2'h3, txByte, 1'b0};
			txTmr <= 16'(BIT_CYC - 1);
			txBitCnt <= 4'h0;
			txIdx <= txIdx + 6'h01;
			if (txIdx < txLen - 6'h02)
				txCrc <= mbs_pkg::mbs_crc_byte(txCrc, txByte);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks.
	a_line_idle: assert property (!txEn |-> txd)
		else $error("Line not idle high while driver off.");
	a_gap_frame: assert property ((state == mbs_pkg::ST_IDLE && rxCnt != 6'h00 &&
		gapCnt == 20'(GAP_CYC - 1)) |=> state == mbs_pkg::ST_CHECK)
		else $error("Frame end not taken after idle gap.");
	a_bcast_silent: assert property ((state == mbs_pkg::ST_CHECK &&
		hdr[0] == mbs_pkg::ADDR_BCAST) |=> state == mbs_pkg::ST_IDLE ##1 !txEn)
		else $error("Broadcast request answered.");
	a_crc_drop: assert property ((state == mbs_pkg::ST_CHECK && rxCrc != 16'h0000)
		|=> state == mbs_pkg::ST_IDLE)
		else $error("Frame with bad check value accepted.");
	a_exc_code: assert property ((txLoad && rspKind == mbs_pkg::RSP_EXC &&
		txIdx == 6'h01) |-> txByte == (hdr[1] | mbs_pkg::EXC_FLAG))
		else $error("Exception reply lacks flagged command.");
	a_exc_cause: assert property ((txLoad && rspKind == mbs_pkg::RSP_EXC &&
		txIdx == 6'h02) |-> txByte == excHeld && excHeld != mbs_pkg::EX_NONE)
		else $error("Exception reply lacks a cause.");
	a_rd_count: assert property ((txLoad && rspKind == mbs_pkg::RSP_READ &&
		txIdx == 6'h02) |-> txByte == {nReq[6:0], 1'b0} &&
		txLen == 6'h05 + txByte[5:0])
		else $error("Read byte count mismatch.");
	a_crc_order: assert property ((txLoad && txIdx == txLen - 6'h02)
		|=> txBusy && txSh[8:1] == $past(txCrc[7:0]))
		else $error("Check value low byte not sent first.");
	a_nv_always: assert property ((state == mbs_pkg::ST_WPUT && nvCmd)
		|=> nvWrStb && nvWrData == $past(pWrData))
		else $error("Persisted write did not request save.");
	a_nv_select: assert property ((state == mbs_pkg::ST_WPUT && !nvCmd && !persistSel)
		|=> !nvWrStb)
		else $error("Save requested with persistence off.");
	a_ctrl_word: assert property ((state == mbs_pkg::ST_WPUT &&
		pWrAddr == {mbs_pkg::SLOT_CTRL, {IDX_BITS{1'b0}}} && regAddr[7:0] == 8'h00 && wK == 4'h0)
		|=> controlWordOne == $past(pWrData))
		else $error("Control word one not updated.");
	c_read_reply: cover property (txLoad && rspKind == mbs_pkg::RSP_READ);
	c_exc_reply: cover property (txLoad && rspKind == mbs_pkg::RSP_EXC);
	c_multi_write: cover property (state == mbs_pkg::ST_WPUT && wK == 4'h1);
endmodule : mbs_slave

// *** bench/mbs_host.sv ***
// Purpose: Host master model that drives requests and collects replies.
// Assumes: The line idles high through its bias when nobody drives it.
// Notes: Reply bytes are queued for the bench; a low stop bit is flagged.
`timescale 1ns/1ps
module mbs_host #(
	parameter int BIT_CYC = 8
) (
	// Clock
	input wire logic core_clk,
	// Serial line
	output logic rxd,
	input wire logic txd,
	input wire logic txEn
);
	logic [7:0] rxQ[$];
	logic frameErr;

	initial
	begin
		rxd = 1'b1;
		frameErr = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// start, eight data, two stops.
	task automatic put_byte(input logic [7:0] b);
		logic [10:0] sh;
		sh = {2'b11, b, 1'b0};
		for (int i = 0; i < 11; i++)
			repeat (BIT_CYC) @(negedge core_clk) rxd = sh[i];
	endtask : put_byte

	// bytes as built; line then idles high for the gap.
	task automatic send(input logic [7:0] f[$]);
		rxQ.delete();
		foreach (f[i])
			put_byte(f[i]);
	endtask : send

	always
	begin : rx
		logic [7:0] b;
		@(negedge core_clk iff (txEn === 1'b1 && txd === 1'b0));
		repeat (BIT_CYC / 2) @(negedge core_clk);
		for (int i = 0; i < 8; i++)
		begin
			repeat (BIT_CYC) @(negedge core_clk);
			b[i] = txd;
		end
		for (int s = 0; s < 2; s++)
		begin
			repeat (BIT_CYC) @(negedge core_clk);
			if (txd !== 1'b1)
				frameErr = 1'b1;
		end
		rxQ.push_back(b);
	end
endmodule : mbs_host

// *** bench/mbs_slave_tb.sv ***
// Purpose: Self-checking bench for the serial parameter slave.
// Assumes: Shortened bit and gap counts; station address is fixed.
// Notes: Parameter memory is not reset, so reads follow writes only.
`timescale 1ns/1ps
module mbs_slave_tb;
	localparam int BITC = 8;
	localparam int GAPC = 308;
	localparam logic [7:0] STN = 8'h05;
	logic core_clk = 1'b0;
	logic rst_b = 1'b0;
	logic rxd, txd, txEn, nvWrStb, persistSel;
	logic [15:0] nvWrAddr, nvWrData, controlWordOne, nvAddr, nvData;
	logic [7:0] req[$];
	logic [7:0] want[$];
	logic [15:0] w[10];
	logic [7:0] idx;
	logic [7:0] grp[7] = '{8'h00, 8'h05, 8'h10, 8'h12, 8'h13, 8'h17, 8'h64};
	logic [47:0] exc[8] = '{48'h07_0101_0001_01, 48'h03_0101_0000_03,
		48'h03_0101_000B_03, 48'h03_1100_0001_02, 48'h03_6600_0001_02,
		48'h03_010F_0002_02, 48'h06_6500_0001_20, 48'h41_6501_0005_20};
	int n_mismatch = 0;
	int n_checks = 0;
	int seed = 32'h3E944BC9;
	int nvCnt = 0;
	int n0;

	always #20 core_clk = ~core_clk;

	mbs_slave #(
		.GAP_CYC(GAPC),
		.BIT_CYC(BITC),
		.IDX_BITS(4)
	) dut (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.stationAddr(STN),
		.rxd(rxd),
		.txd(txd),
		.txEn(txEn),
		.nvWrStb(nvWrStb),
		.nvWrAddr(nvWrAddr),
		.nvWrData(nvWrData),
		.controlWordOne(controlWordOne),
		.persistSel(persistSel)
	);

	mbs_host #(.BIT_CYC(BITC)) host (.core_clk(core_clk), .rxd(rxd), .txd(txd), .txEn(txEn));

	// Save pulses carry no handshake, so they are counted as they pass.
	always @(posedge core_clk)
		if (nvWrStb === 1'b1)
		begin
			nvCnt <= nvCnt + 1;
			nvAddr <= nvWrAddr;
			nvData <= nvWrData;
		end

	////////////////////////////////////////////////////////////////////////////////
	task automatic final_report();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : final_report

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("FAIL %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	function automatic logic [15:0] crc16(input logic [7:0] q[$]);
		logic [15:0] c;
		c = 16'hFFFF;
		foreach (q[i])
		begin
			c = c ^ {8'h00, q[i]};
			for (int k = 0; k < 8; k++)
				c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
		end
		return c;
	endfunction : crc16

	task automatic seal(ref logic [7:0] q[$]);
		logic [15:0] c;
		c = crc16(q);
		q.push_back(c[7:0]);
		q.push_back(c[15:8]);
	endtask : seal

	task automatic frame(input logic [7:0] a, input logic [7:0] c, input logic [15:0] r,
		input logic [15:0] v);
		req = {a, c, r[15:8], r[7:0], v[15:8], v[7:0]};
		seal(req);
	endtask : frame

	task automatic mframe(input logic [7:0] c, input logic [15:0] r, input int n);
		req = {STN, c, r[15:8], r[7:0], 8'h00, 8'(n), 8'(2 * n)};
		for (int i = 0; i < n; i++)
			req = {req, w[i][15:8], w[i][7:0]};
		seal(req);
		want = {STN, c, r[15:8], r[7:0], 8'h00, 8'(n)};
		seal(want);
	endtask : mframe

	task automatic timeout(input string what);
		n_mismatch++;
		$display("FAIL %s expected reply seen timeout", what);
		final_report();
	endtask : timeout

	// An empty expectation means the slave must stay silent.
	task automatic xact(input string what);
		int t;
		host.send(req);
		t = 0;
		while (txEn !== 1'b1 && t < GAPC + 100)
		begin
			@(negedge core_clk);
			t++;
		end
		if (want.size() == 0)
		begin
			check({what, " quiet"}, txEn, 1'b0);
			return;
		end
		if (txEn !== 1'b1)
			timeout(what);
		t = 0;
		while (txEn !== 1'b0)
		begin
			@(negedge core_clk);
			t++;
			if (t > 4000)
				timeout(what);
		end
		repeat (GAPC + 20) @(negedge core_clk);
		check({what, " idle"}, txd, 1'b1);
		check({what, " length"}, host.rxQ.size(), want.size());
		foreach (want[i])
			if (i < host.rxQ.size())
				check({what, " byte"}, host.rxQ[i], want[i]);
	endtask : xact

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (6) @(negedge core_clk);
		rst_b = 1'b1;
		@(negedge core_clk);
		check("txEn reset", txEn, 1'b0);
		check("ctrl reset", controlWordOne, mbs_pkg::CTRL_WORD_ONE_RST);
		check("persist reset", persistSel, mbs_pkg::PERSIST_SEL_RST);
		frame(STN, 8'h06, 16'h0101, 16'h1388);
		want = req;
		xact("write 0101");
		frame(STN, 8'h03, 16'h0101, 16'h0001);
		want = {STN, 8'h03, 8'h02, 8'h13, 8'h88, 8'h44, 8'hD2};
		xact("read 0101");
		check("save count 06", nvCnt, 0);
		frame(8'h00, 8'h03, 16'h0101, 16'h0001);
		want = {};
		xact("broadcast");
		frame(8'h06, 8'h03, 16'h0101, 16'h0001);
		xact("foreign");
		frame(STN, 8'h03, 16'h0101, 16'h0001);
		req[7] = req[7] ^ 8'h01;
		xact("bad crc");
		foreach (exc[i])
		begin
			frame(STN, exc[i][47:40], exc[i][39:24], exc[i][23:8]);
			want = {STN, exc[i][47:40] | 8'h80, exc[i][7:0]};
			seal(want);
			xact("exception");
		end
		req = {STN, 8'h03, 8'h01, 8'h01, 8'h00, 8'h01, 8'h00};
		seal(req);
		want = {STN, 8'h83, 8'h18};
		seal(want);
		xact("long frame");
		req = {STN, 8'h03, 8'h01, 8'h01, 8'h00, 8'h01};
		for (int i = 0; i < 27; i++)
			req = {req, 8'h00};
		seal(req);
		want = {};
		xact("oversize");
		idx = {4'h0, 4'($random(seed))} | 8'h01;
		foreach (grp[i])
		begin
			w[i] = 16'($random(seed));
			frame(STN, 8'h06, {grp[i], idx}, w[i]);
			want = req;
			xact("group write");
		end
		foreach (grp[i])
		begin
			frame(STN, 8'h03, {grp[i], idx}, 16'h0001);
			want = {STN, 8'h03, 8'h02, w[i][15:8], w[i][7:0]};
			seal(want);
			xact("group read");
		end
		foreach (w[i])
			w[i] = 16'($random(seed));
		mframe(8'h10, 16'h6400, 10);
		xact("multi write");
		check("ctrl word", controlWordOne, w[0]);
		check("save count 10", nvCnt, 0);
		frame(STN, 8'h03, 16'h6400, 16'h000A);
		want = {STN, 8'h03, 8'h14};
		foreach (w[i])
			want = {want, w[i][15:8], w[i][7:0]};
		seal(want);
		xact("multi read");
		n0 = nvCnt;
		frame(STN, 8'h41, 16'h0302, w[3]);
		want = req;
		xact("nv single");
		check("save count 41", nvCnt - n0, 1);
		check("save addr 41", nvAddr, 16'h0302);
		check("save data 41", nvData, w[3]);
		n0 = nvCnt;
		mframe(8'h43, 16'h0306, 3);
		xact("nv multi");
		check("save count 43", nvCnt - n0, 3);
		check("save addr 43", nvAddr, 16'h0308);
		check("save data 43", nvData, w[2]);
		frame(STN, 8'h06, mbs_pkg::REG_PERSIST_SEL, 16'h0001);
		want = req;
		xact("persist on");
		check("persist sel", persistSel, 1'b1);
		n0 = nvCnt;
		frame(STN, 8'h06, 16'h0500, w[4]);
		want = req;
		xact("persist single");
		check("save count 06 on", nvCnt - n0, 1);
		check("save addr 06 on", nvAddr, 16'h0500);
		n0 = nvCnt;
		mframe(8'h10, 16'h0700, 2);
		xact("persist multi");
		check("save count 10 on", nvCnt - n0, 2);
		check("stop bits", host.frameErr, 1'b0);
		final_report();
	end
endmodule : mbs_slave_tb
